// file: hdl/usb_arb_pkg.sv
// Constants and types shared by the endpoint arbiter event logic.
package usb_arb_pkg;
	localparam int NUM_EP = 8;
	localparam int NUM_EV = 5;
	localparam int CNT_W = 10;
	localparam logic [1:0] MODE_MANUAL = 2'h0;
	localparam logic [1:0] MODE_MANUAL_DMA = 2'h1;
	localparam logic [1:0] MODE_AUTO_DMA = 2'h2;
	localparam logic [CNT_W-1:0] MEM_BYTES = 10'h200;
	localparam logic [CNT_W-1:0] COMMON_BYTES = 10'h100;
	localparam logic [CNT_W-1:0] DMA_THRESHOLD = 10'h020;
	localparam logic [CNT_W-1:0] DED_UNIT = 10'h004;
	localparam logic [CNT_W-1:0] ONE_CNT = 10'h001;
	localparam logic [7:0] OFS_LINK_RAW = 8'h00;
	localparam logic [7:0] OFS_LINK_MASK = 8'h04;
	localparam logic [7:0] OFS_LINK_GATED = 8'h08;
	localparam logic [7:0] OFS_SLEEP_INFO = 8'h0c;
	localparam logic [7:0] OFS_ARB_RAW_BASE = 8'h10;
	localparam logic [7:0] ARB_STRIDE = 8'h04;
	localparam logic [7:0] OFS_ARB_ENABLE = 8'h24;
	localparam logic [7:0] OFS_BUF_SIZE = 8'h28;
	localparam logic [2:0] OFS_EP_CFG_PAGE = 3'h2;
	localparam logic [2:0] OFS_EP_CNT_PAGE = 3'h3;
	localparam int LINK_LPM_BIT = 0;
	localparam int LINK_WAKE_BIT = 1;
	localparam int CFG_MODE_LSB = 0;
	localparam int CFG_DIR_BIT = 2;
	localparam int CFG_REQ_BIT = 3;
	localparam int EV_GRANT = 0;
	localparam int EV_IN_FULL = 1;
	localparam int EV_OVERFLOW = 2;
	localparam int EV_UNDERFLOW = 3;
	localparam int EV_TERMIN = 4;
	localparam logic [1:0] RST_LINK_MASK = 2'h0;
	localparam logic [NUM_EV-1:0] RST_ARB_ENABLE = 5'h00;
	localparam logic [3:0] RST_BUF_SIZE = 4'h7;
	typedef enum logic [1:0] {PWR_ACTIVE = 2'h0, PWR_DEEP_SLEEP = 2'h1, PWR_HIBERNATE = 2'h3} power_mode_t;
	typedef enum logic {PH_IDLE = 1'b0, PH_REQ = 1'b1} req_phase_t;
	typedef struct packed {
		logic [1:0] mode;
		logic dir_in;
		logic [CNT_W-1:0] byte_count;
	} ep_cfg_t;
	typedef struct packed {
		logic buf_wr;
		logic buf_rd;
		logic in_token;
		logic burst_end;
	} ep_traffic_t;
	typedef struct packed {
		logic termin;
		logic underflow;
		logic overflow;
		logic in_full;
		logic grant;
	} ep_event_t;
endpackage : usb_arb_pkg

// file: hdl/link_events.sv
// Link power management and wake event status with write-one-to-clear bits.
`timescale 1ns/1ps
module link_events
	import usb_arb_pkg::*;
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic lpm_token,
	input wire logic dp_level,
	input wire power_mode_t power_mode,
	input wire logic [1:0] raw_clear,
	input wire logic [1:0] mask,
	output logic [1:0] raw,
	output logic [1:0] gated,
	output logic asleep
);
	typedef struct packed {
		logic [1:0] raw;
		logic asleep;
	} link_state_t;
	link_state_t state;
	link_state_t next_state;
	logic wake_seen;

	always_comb begin
		wake_seen = !dp_level && power_mode == PWR_ACTIVE; // [R3] [R4]
		next_state.raw = {wake_seen, lpm_token} | (state.raw & ~raw_clear); // [R1] [R24]
		next_state.asleep = wake_seen ? 1'b0 : (lpm_token | state.asleep); // [R22]
		gated = state.raw & mask; // [R2]
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign raw = state.raw;
	assign asleep = state.asleep;

	a_wake_blocked_low_power: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R4]
		(!raw[LINK_WAKE_BIT] && power_mode != PWR_ACTIVE) |=> !raw[LINK_WAKE_BIT])
		else $error("Wake status set outside active mode.");
	a_clear_then_hold: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R24]
		(raw[LINK_LPM_BIT] && !raw_clear[LINK_LPM_BIT]) |=> raw[LINK_LPM_BIT])
		else $error("Link power status dropped without a clear.");
	a_wake_ends_sleep: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R22]
		(asleep && !dp_level && power_mode == PWR_ACTIVE) |=> (!asleep && raw[LINK_WAKE_BIT]))
		else $error("Wake did not end link sleep.");
endmodule : link_events

// file: hdl/ep_channel.sv
// Endpoint buffer accounting, DMA request handshake and arbiter event detection.
`timescale 1ns/1ps
module ep_channel
	import usb_arb_pkg::*;
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire ep_cfg_t cfg,
	input wire logic [3:0] buf_size,
	input wire logic manual_req,
	input wire ep_traffic_t traffic,
	output ep_event_t events,
	output logic dma_req,
	output logic dma_termin,
	output logic tx_ready
);
	typedef struct packed {
		req_phase_t phase;
		logic [CNT_W-1:0] level;
		logic [CNT_W-1:0] moved;
		logic token_seen;
		logic termin;
		logic ready;
	} ep_state_t;
	ep_state_t state;
	ep_state_t next_state;
	logic auto_mode;
	logic dma_mode;
	logic [CNT_W-1:0] dedicated;
	logic [CNT_W-1:0] capacity;
	logic wr_ok;
	logic rd_ok;
	logic dma_move;
	logic auto_req;

	always_comb begin
		auto_mode = cfg.mode == MODE_AUTO_DMA; // [R18]
		dma_mode = cfg.mode != MODE_MANUAL; // [R18]
		dedicated = {4'h0, buf_size, 2'h0} + DED_UNIT; // [R10] [R23]
		capacity = auto_mode ? (state.token_seen ? dedicated + COMMON_BYTES : dedicated) : MEM_BYTES; // [R13] [R23]
		wr_ok = traffic.buf_wr && state.level < capacity;
		rd_ok = traffic.buf_rd && state.level != 10'h000;
		dma_move = cfg.dir_in ? wr_ok : rd_ok;
		auto_req = auto_mode && (cfg.dir_in ? (state.token_seen && state.level + DMA_THRESHOLD <= capacity
			&& state.moved < cfg.byte_count) : state.level >= DMA_THRESHOLD); // [R20] [R21]
		events.grant = dma_mode && traffic.burst_end && state.phase == PH_REQ; // [R6] [R7] [R17]
		events.in_full = cfg.dir_in && wr_ok && (auto_mode ? (!state.token_seen && state.level + ONE_CNT == dedicated)
			: state.moved + ONE_CNT == cfg.byte_count); // [R9] [R10] [R11]
		events.overflow = auto_mode && cfg.dir_in && traffic.buf_wr && !wr_ok; // [R12] [R13]
		events.underflow = dma_mode && cfg.dir_in && traffic.buf_rd && !rd_ok; // [R14]
		events.termin = dma_mode && dma_move && state.moved + ONE_CNT == cfg.byte_count; // [R15]
		next_state = state;
		next_state.level = state.level + {9'h000, wr_ok} - {9'h000, rd_ok};
		if (events.termin) begin
			next_state.moved = 10'h000;
		end else if (dma_move && (dma_mode || cfg.dir_in)) begin
			next_state.moved = state.moved + ONE_CNT;
		end
		next_state.termin = events.termin; // [R15]
		next_state.token_seen = traffic.in_token | (state.token_seen & !events.termin);
		next_state.ready = cfg.dir_in && (auto_mode ? state.level >= DMA_THRESHOLD || state.level >= cfg.byte_count
			: state.level >= cfg.byte_count); // [R19] [R20]
		case (state.phase)
			PH_IDLE: begin
				if ((manual_req && cfg.mode == MODE_MANUAL_DMA) || auto_req) begin
					next_state.phase = PH_REQ; // [R7]
				end
			end
			PH_REQ: begin
				if (traffic.burst_end) begin
					next_state.phase = PH_IDLE; // [R8] [R17]
				end
			end
			default: begin
				next_state.phase = PH_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign dma_req = state.phase == PH_REQ; // [R16]
	assign dma_termin = state.termin;
	assign tx_ready = state.ready;

	a_grant_needs_request: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R6]
		events.grant |-> (dma_req && traffic.burst_end) ##1 !dma_req)
		else $error("Grant without outstanding request.");
	a_request_held_once: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R8]
		(dma_req && !traffic.burst_end) |=> (dma_req && $stable(state.phase)))
		else $error("Pending request dropped before burst end.");
	a_overflow_auto_in: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R12]
		events.overflow |-> (cfg.mode == MODE_AUTO_DMA && cfg.dir_in && state.level == capacity))
		else $error("Overflow outside cut-through IN.");
	a_underflow_dma_in: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R14]
		events.underflow |-> (cfg.dir_in && cfg.mode != MODE_MANUAL && state.level == 10'h000))
		else $error("Underflow flagged on wrong endpoint.");
	a_termin_pulse_out: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R15]
		events.termin |=> (dma_termin && state.moved == 10'h000) ##1 !dma_termin[*1])
		else $error("Termination pulse missing or stretched.");
endmodule : ep_channel

// file: hdl/usb_endpoint_arbiter_events.sv
// Register file, link events and per-endpoint arbiter events of the USB endpoint arbiter.
//
// Functional notes
// [R1] LPM token sets its sticky status; interrupt raised only when masked in.
// [R2] Each link event's gated status is raw status AND mask.
// [R3] Low level on D+ sets wake status with its own mask and gated bit.
// [R4] Wake events are produced only in active power mode.
// [R5] Arbiter interrupt is OR of five event groups each ANDed with enable.
// [R6] In DMA modes burst end on a pending request sets grant status.
// [R7] One grant status per endpoint, shared by manual and automatic requests.
// [R8] Only the first request before grant reaches the DMA; later ones dropped.
// [R9] Store-and-forward IN: buffer full when written bytes equal byte count.
// [R10] Cut-through IN: buffer full when dedicated buffer, sized by 4-bit field, fills.
// [R11] Buffer full status only for IN endpoints, in any of three modes.
// [R12] Overflow only in cut-through when DMA writes past remaining space.
// [R13] Cut-through IN uses common area only after its IN token arrived.
// [R14] Underflow only for IN endpoints in DMA modes when buffer runs dry.
// [R15] Termination pulse and status once DMA moved the full byte count.
// [R16] Eight DMA request outputs, one per data endpoint channel.
// [R17] DMA controller returns burst end on the serviced endpoint's line.
// [R18] Each endpoint selects manual, manual DMA or automatic DMA mode.
// [R19] Firmware places whole IN packet in shared memory before the token.
// [R20] Cut-through IN starts sending once enough bytes are buffered.
// [R21] Cut-through OUT requests DMA once the threshold of bytes is present.
// [R22] Leaving link sleep works like a wake from suspend.
// [R23] Automatic allocation gives each endpoint a dedicated buffer plus common area.
// [R24] Raw status bits stay set until software writes one to clear.
//
// Our own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
module usb_endpoint_arbiter_events
	import usb_arb_pkg::*;
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic lpm_token,
	input wire logic [7:0] lpm_info,
	input wire logic dp_level,
	input wire power_mode_t power_mode,
	input wire logic [NUM_EP-1:0] ep_buf_wr,
	input wire logic [NUM_EP-1:0] ep_buf_rd,
	input wire logic [NUM_EP-1:0] ep_in_token,
	input wire logic [NUM_EP-1:0] dma_burst_end,
	output logic [NUM_EP-1:0] dma_req,
	output logic [NUM_EP-1:0] dma_termin,
	output logic [NUM_EP-1:0] tx_ready,
	output logic link_irq,
	output logic arb_irq,
	output logic link_asleep
);
	typedef struct packed {
		logic [1:0] link_mask;
		logic [NUM_EV-1:0] arb_enable;
		logic [3:0] buf_size;
		ep_cfg_t [NUM_EP-1:0] cfg;
		logic [NUM_EV-1:0][NUM_EP-1:0] arb_raw;
		logic [7:0] sleep_info;
		logic [31:0] rdata;
		logic link_irq;
		logic arb_irq;
		logic [NUM_EP-1:0] manual_req;
	} regs_t;

	regs_t state;
	regs_t next_state;
	logic [1:0] link_clear;
	logic [1:0] link_raw;
	logic [1:0] link_gated;
	logic [NUM_EV-1:0][NUM_EP-1:0] arb_clear;
	logic [NUM_EV-1:0][NUM_EP-1:0] ev_vec;
	logic [NUM_EV-1:0] arb_any;
	logic arb_hit;
	logic [2:0] arb_sel;
	logic [2:0] ep_idx;
	logic cfg_hit;
	logic cnt_hit;
	ep_event_t [NUM_EP-1:0] ep_events;
	ep_traffic_t [NUM_EP-1:0] traffic;

	link_events link_unit (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.lpm_token(lpm_token),
		.dp_level(dp_level),
		.power_mode(power_mode),
		.raw_clear(link_clear),
		.mask(state.link_mask),
		.raw(link_raw),
		.gated(link_gated),
		.asleep(link_asleep)
	);

	generate
		for (genvar i = 0; i < NUM_EP; i++) begin : g_ep
			assign traffic[i] = {ep_buf_wr[i], ep_buf_rd[i], ep_in_token[i], dma_burst_end[i]};
			ep_channel ep_unit (
				.sys_clk(sys_clk),
				.sys_rst(sys_rst),
				.cfg(state.cfg[i]),
				.buf_size(state.buf_size),
				.manual_req(state.manual_req[i]),
				.traffic(traffic[i]),
				.events(ep_events[i]),
				.dma_req(dma_req[i]), // [R16]
				.dma_termin(dma_termin[i]),
				.tx_ready(tx_ready[i])
			);
			for (genvar e = 0; e < NUM_EV; e++) begin : g_ev
				assign ev_vec[e][i] = ep_events[i][e];
			end
		end
	endgenerate

	always_comb begin
		ep_idx = reg_addr[4:2];
		cfg_hit = reg_addr[7:5] == OFS_EP_CFG_PAGE;
		cnt_hit = reg_addr[7:5] == OFS_EP_CNT_PAGE;
		arb_hit = 1'b0;
		arb_sel = 3'h0;
		for (int e = 0; e < NUM_EV; e++) begin
			if (reg_addr == OFS_ARB_RAW_BASE + ARB_STRIDE * 8'(e)) begin
				arb_hit = 1'b1;
				arb_sel = 3'(e);
			end
		end
		for (int e = 0; e < NUM_EV; e++) begin
			arb_any[e] = |state.arb_raw[e];
		end
	end

	always_comb begin
		next_state = state;
		link_clear = 2'h0;
		arb_clear = '0;
		next_state.rdata = 32'h0000_0000;
		next_state.manual_req = '0;
		if (reg_wr) begin
			if (reg_addr == OFS_LINK_RAW) begin
				link_clear = reg_wdata[1:0]; // [R24]
			end else if (reg_addr == OFS_LINK_MASK) begin
				next_state.link_mask = reg_wdata[1:0];
			end else if (arb_hit) begin
				arb_clear[arb_sel] = reg_wdata[NUM_EP-1:0]; // [R24]
			end else if (reg_addr == OFS_ARB_ENABLE) begin
				next_state.arb_enable = reg_wdata[NUM_EV-1:0];
			end else if (reg_addr == OFS_BUF_SIZE) begin
				next_state.buf_size = reg_wdata[3:0]; // [R10]
			end else if (cfg_hit) begin
				next_state.cfg[ep_idx].mode = reg_wdata[CFG_MODE_LSB+:2]; // [R18]
				next_state.cfg[ep_idx].dir_in = reg_wdata[CFG_DIR_BIT];
				next_state.manual_req[ep_idx] = reg_wdata[CFG_REQ_BIT]; // [R7]
			end else if (cnt_hit) begin
				next_state.cfg[ep_idx].byte_count = reg_wdata[CNT_W-1:0]; // [R9]
			end
		end
		if (reg_rd) begin
			if (reg_addr == OFS_LINK_RAW) begin
				next_state.rdata = {30'h0000_0000, link_raw};
			end else if (reg_addr == OFS_LINK_MASK) begin
				next_state.rdata = {30'h0000_0000, state.link_mask};
			end else if (reg_addr == OFS_LINK_GATED) begin
				next_state.rdata = {30'h0000_0000, link_gated}; // [R2]
			end else if (reg_addr == OFS_SLEEP_INFO) begin
				next_state.rdata = {24'h00_0000, state.sleep_info};
			end else if (arb_hit) begin
				next_state.rdata = {24'h00_0000, state.arb_raw[arb_sel]};
			end else if (reg_addr == OFS_ARB_ENABLE) begin
				next_state.rdata = {27'h000_0000, state.arb_enable};
			end else if (reg_addr == OFS_BUF_SIZE) begin
				next_state.rdata = {28'h000_0000, state.buf_size};
			end else if (cfg_hit) begin
				next_state.rdata = {28'h000_0000, dma_req[ep_idx], state.cfg[ep_idx].dir_in, state.cfg[ep_idx].mode};
			end else if (cnt_hit) begin
				next_state.rdata = {22'h00_0000, state.cfg[ep_idx].byte_count};
			end
		end
		for (int e = 0; e < NUM_EV; e++) begin
			next_state.arb_raw[e] = ev_vec[e] | (state.arb_raw[e] & ~arb_clear[e]); // [R6] [R24]
		end
		if (lpm_token) begin
			next_state.sleep_info = lpm_info; // [R1]
		end
		next_state.link_irq = |link_gated; // [R1] [R3]
		next_state.arb_irq = |(state.arb_enable & arb_any); // [R5]
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state <= '0;
			state.link_mask <= RST_LINK_MASK;
			state.arb_enable <= RST_ARB_ENABLE;
			state.buf_size <= RST_BUF_SIZE;
		end else begin
			state <= next_state;
		end
	end

	assign reg_rdata = state.rdata;
	assign link_irq = state.link_irq;
	assign arb_irq = state.arb_irq;

	a_lpm_sets_raw: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R1]
		lpm_token |=> (link_raw[LINK_LPM_BIT] && state.sleep_info == $past(lpm_info)))
		else $error("LPM token did not set status.");

	a_lpm_irq_masked: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R1]
		(link_raw[LINK_LPM_BIT] && !state.link_mask[LINK_LPM_BIT] && !link_gated[LINK_WAKE_BIT]) |=> !link_irq)
		else $error("Masked LPM event raised interrupt.");

	a_link_gated_and: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R2]
		link_gated == (link_raw & state.link_mask))
		else $error("Gated link status is not raw AND mask.");

	a_wake_sets_raw: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R3]
		(!dp_level && power_mode == PWR_ACTIVE) |=> link_raw[LINK_WAKE_BIT] ##1 link_irq == state.link_mask[LINK_WAKE_BIT]
			|| link_gated[LINK_LPM_BIT])
		else $error("D+ low did not raise wake status.");

	a_arb_irq_or: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R5]
		arb_irq == $past(|(state.arb_enable & arb_any)))
		else $error("Arbiter interrupt is not the gated OR.");

	a_grant_sticky: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R6]
		(dma_req[0] && dma_burst_end[0] && state.cfg[0].mode != MODE_MANUAL) |=> state.arb_raw[EV_GRANT][0])
		else $error("Burst end did not set grant status.");

	a_arb_clear_w1c: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R24]
		(reg_wr && reg_addr == OFS_ARB_RAW_BASE && reg_wdata[0] && !ev_vec[EV_GRANT][0])
			|=> !state.arb_raw[EV_GRANT][0])
		else $error("Write one did not clear grant status.");

	a_arb_set_wins: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R24]
		ev_vec[EV_TERMIN][2] |=> state.arb_raw[EV_TERMIN][2])
		else $error("Termination event lost against a clear.");

	a_rdata_one_cycle: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!reg_rd |=> reg_rdata == 32'h0000_0000)
		else $error("Read data held beyond its cycle.");

endmodule : usb_endpoint_arbiter_events

// file: verif/dma_model.sv
// Behavioural DMA controller that answers endpoint requests with a burst-end pulse.
`timescale 1ns/1ps
module dma_model
	import usb_arb_pkg::*;
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic slow,
	input wire logic [NUM_EP-1:0] dma_req,
	output logic [NUM_EP-1:0] burst_end
);
	logic [3:0] wait_cnt [NUM_EP];

	// Each channel waits two or nine cycles, then pulses burst end once per request.
	always_ff @(posedge sys_clk) begin
		for (int n = 0; n < NUM_EP; n++) begin
			burst_end[n] <= 1'b0;
			if (sys_rst || !dma_req[n] || burst_end[n]) begin
				wait_cnt[n] <= slow ? 4'h8 : 4'h1;
			end else if (wait_cnt[n] == 4'h0) begin
				burst_end[n] <= 1'b1;
			end else begin
				wait_cnt[n] <= wait_cnt[n] - 4'h1;
			end
		end
	end
endmodule : dma_model

// file: verif/usb_endpoint_arbiter_events_test.sv
// Self-checking bench for the endpoint arbiter event logic.
`timescale 1ns/1ps
module usb_endpoint_arbiter_events_test
	import usb_arb_pkg::*;
;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic lpm_token = 1'b0;
	logic [7:0] lpm_info = 8'h00;
	logic dp_level = 1'b1;
	power_mode_t power_mode = PWR_ACTIVE;
	logic [7:0] ep_buf_wr = 8'h00, ep_buf_rd = 8'h00, ep_in_token = 8'h00;
	logic [7:0] dma_burst_end, dma_req, dma_termin, tx_ready;
	logic link_irq, arb_irq, link_asleep;
	logic slow = 1'b1;
	int n_errors = 0;
	int checks = 0;
	int seed = 32'h2261279a;
	logic [31:0] exp_q[$];
	logic rd_seen = 1'b0;
	logic [7:0] info, a;
	logic [31:0] k;

	usb_endpoint_arbiter_events usb_endpoint_arbiter_events_inst (.sys_clk, .sys_rst, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .lpm_token, .lpm_info, .dp_level, .power_mode, .ep_buf_wr, .ep_buf_rd,
		.ep_in_token, .dma_burst_end, .dma_req, .dma_termin, .tx_ready, .link_irq, .arb_irq, .link_asleep);
	dma_model dma_model_inst (.sys_clk, .sys_rst, .slow, .dma_req, .burst_end(dma_burst_end));

	always #10 sys_clk = ~sys_clk;

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task automatic complete_run;
		$display("checks=%0d n_errors=%0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : complete_run

	// Read data stand only in the cycle after the strobe; the oldest note is compared there.
	always @(posedge sys_clk) begin
		rd_seen <= reg_rd;
	end
	always @(negedge sys_clk) begin
		if (rd_seen && exp_q.size() > 0) begin
			check(reg_rdata, exp_q.pop_front());
		end
	end

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : tick

	task automatic wr(input logic [7:0] adr, input logic [31:0] d);
		reg_addr <= adr;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		@(posedge sys_clk);
	endtask : wr

	task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
		exp_q.push_back(exp);
		reg_addr <= adr;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(posedge sys_clk);
	endtask : rd

	task automatic bytes(input logic [7:0] wm, input logic [7:0] rm, input int cnt);
		ep_buf_wr <= wm;
		ep_buf_rd <= rm;
		repeat (cnt) @(posedge sys_clk);
		ep_buf_wr <= 8'h00;
		ep_buf_rd <= 8'h00;
		@(posedge sys_clk);
	endtask : bytes

	task automatic await(input int sel, input int n, input logic lvl);
		logic [7:0] v;
		checks++;
		for (int i = 0; i < 40; i++) begin
			@(negedge sys_clk);
			v = sel == 0 ? dma_req : (sel == 1 ? dma_termin : tx_ready);
			if (v[n] === lvl) begin
				@(posedge sys_clk);
				return;
			end
		end
		n_errors++;
		$display("CHECK FAILED t=%0t got=%h exp=%h", $time, v[n], lvl);
		complete_run();
	endtask : await

	function automatic logic [7:0] ev(input int e);
		return OFS_ARB_RAW_BASE + ARB_STRIDE * 8'(e);
	endfunction : ev

	task automatic clr;
		for (int e = 0; e < NUM_EV; e++) begin
			wr(ev(e), 32'hff);
		end
	endtask : clr

	task automatic done(input string s);
		$display("test %s finished", s);
	endtask : done

	initial begin
		#1000000;
		n_errors++;
		complete_run();
	end

	initial begin
		repeat (6) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		rd(OFS_LINK_MASK, 32'h0);
		rd(OFS_ARB_ENABLE, 32'h0);
		rd(OFS_BUF_SIZE, 32'h7);
		rd(8'h30, 32'h0);
		done("reset");
		info = 8'($random(seed));
		lpm_info <= info;
		lpm_token <= 1'b1;
		tick(1);
		lpm_token <= 1'b0;
		tick(2);
		check(link_asleep, 32'h1);
		rd(OFS_LINK_RAW, 32'h1);
		rd(OFS_LINK_GATED, 32'h0);
		rd(OFS_SLEEP_INFO, {24'h0, info});
		check(link_irq, 32'h0);
		wr(OFS_LINK_MASK, 32'h1);
		tick(2);
		check(link_irq, 32'h1);
		rd(OFS_LINK_GATED, 32'h1);
		wr(OFS_LINK_RAW, 32'h0);
		rd(OFS_LINK_RAW, 32'h1);
		wr(OFS_LINK_RAW, 32'h1);
		rd(OFS_LINK_RAW, 32'h0);
		done("lpm");
		wr(OFS_LINK_MASK, 32'h2);
		power_mode <= PWR_DEEP_SLEEP;
		dp_level <= 1'b0;
		tick(3);
		power_mode <= PWR_HIBERNATE;
		tick(3);
		rd(OFS_LINK_RAW, 32'h0);
		power_mode <= PWR_ACTIVE;
		tick(3);
		dp_level <= 1'b1;
		tick(2);
		check(link_asleep, 32'h0);
		check(link_irq, 32'h1);
		rd(OFS_LINK_GATED, 32'h2);
		wr(OFS_LINK_RAW, 32'h2);
		rd(OFS_LINK_RAW, 32'h0);
		done("wake");
		wr(OFS_ARB_ENABLE, 32'h1);
		for (int n = 0; n < NUM_EP; n++) begin
			a = {OFS_EP_CFG_PAGE, 3'(n), 2'h0};
			wr(a, 32'h9);
			wr(a, 32'h9);
			check(dma_req[n], 32'h1);
			await(0, n, 1'b0);
			tick(6);
			check(dma_req, 32'h0);
			check(arb_irq, 32'h1);
			rd(ev(EV_GRANT), 32'(1 << n));
			wr(ev(EV_GRANT), 32'hff);
		end
		slow <= 1'b0;
		wr(OFS_ARB_ENABLE, 32'h1e);
		wr(8'h44, 32'h9);
		await(0, 1, 1'b1);
		await(0, 1, 1'b0);
		tick(3);
		check(arb_irq, 32'h0);
		wr(OFS_ARB_ENABLE, 32'h1);
		tick(1);
		check(arb_irq, 32'h1);
		wr(ev(EV_GRANT), 32'hff);
		wr(8'h40, 32'h8);
		tick(4);
		check(dma_req, 32'h0);
		wr(8'h40, 32'hb);
		tick(4);
		check(dma_req, 32'h0);
		rd(ev(EV_GRANT), 32'h0);
		done("dma request");
		k = 32'h3 + ($unsigned($random(seed)) % 8);
		wr(8'h48, 32'h5);
		wr(8'h68, k);
		clr();
		bytes(8'h04, 8'h00, k - 1);
		rd(ev(EV_IN_FULL), 32'h0);
		ep_buf_wr <= 8'h04;
		tick(1);
		ep_buf_wr <= 8'h00;
		await(1, 2, 1'b1);
		rd(ev(EV_IN_FULL), 32'h4);
		rd(ev(EV_TERMIN), 32'h4);
		bytes(8'h00, 8'h04, k);
		rd(ev(EV_UNDERFLOW), 32'h0);
		bytes(8'h00, 8'h04, 1);
		rd(ev(EV_UNDERFLOW), 32'h4);
		wr(8'h4c, 32'h1);
		wr(8'h6c, 32'h2);
		clr();
		bytes(8'h08, 8'h00, 1);
		bytes(8'h00, 8'h08, 1);
		bytes(8'h08, 8'h00, 2);
		rd(ev(EV_IN_FULL), 32'h0);
		done("store and forward");
		wr(OFS_BUF_SIZE, 32'h0);
		wr(8'h50, 32'h6);
		wr(8'h70, 32'h64);
		clr();
		bytes(8'h10, 8'h00, 3);
		rd(ev(EV_IN_FULL), 32'h0);
		bytes(8'h10, 8'h00, 1);
		rd(ev(EV_IN_FULL), 32'h10);
		check(dma_req[4], 32'h0);
		check(tx_ready[4], 32'h0);
		bytes(8'h10, 8'h00, 1);
		rd(ev(EV_OVERFLOW), 32'h10);
		ep_in_token <= 8'h10;
		tick(1);
		ep_in_token <= 8'h00;
		tick(1);
		await(0, 4, 1'b1);
		bytes(8'h10, 8'h00, 28);
		await(2, 4, 1'b1);
		done("cut through in");
		wr(OFS_BUF_SIZE, 32'h7);
		wr(8'h54, 32'h2);
		wr(8'h74, 32'h100);
		bytes(8'h20, 8'h00, 31);
		tick(3);
		check(dma_req[5], 32'h0);
		bytes(8'h20, 8'h00, 1);
		await(0, 5, 1'b1);
		done("cut through out");
		complete_run();
	end
endmodule : usb_endpoint_arbiter_events_test
